/* core/sswx_defs.svh */
`ifndef SSWX_DEFS_SVH
`define SSWX_DEFS_SVH

// register byte offsets
`define SSWX_OFS_CMD    12'h000
`define SSWX_OFS_ACC    12'h004
`define SSWX_OFS_STAT   12'h008
`define SSWX_OFS_DIR1   12'h00C
`define SSWX_OFS_DIR2   12'h010
`define SSWX_OFS_DIR3   12'h014

// file register window 0x200..0x3FC, one byte per word
`define SSWX_WIN_SEL    11:9
`define SSWX_WIN_BASE   3'h1
`define SSWX_WIN_IDX    8:2
`define SSWX_FILE_LAST  127

// direction register selectors
`define SSWX_DIR_SEL1   7'h05
`define SSWX_DIR_SEL2   7'h06
`define SSWX_DIR_SEL3   7'h07

// reset values
`define SSWX_ACC_RST    8'h00
`define SSWX_DIR_RST    8'hFF
`define SSWX_STAT_RST   3'h0
`define SSWX_CMD_RST    32'h0000_0007

// datapath field positions
`define SSWX_NIB_LO     3:0
`define SSWX_NIB_HI     7:4
`define SSWX_BYTE       7:0
`define SSWX_FULL_CY    8
`define SSWX_NIB_CY     4
`define SSWX_SUB_C      9
`define SSWX_SUB_DC     8
`define SSWX_STAT_BITS  2:0

`endif

/* core/sswx_pkg.sv */
package sswx_pkg;

  typedef enum logic [2:0] {
    literal_minus_acc_op    = 3'h0,
    register_minus_acc_op   = 3'h1,
    subtract_with_borrow_op = 3'h2,
    nibble_exchange_op      = 3'h3,
    direction_load_op       = 3'h4,
    literal_xor_op          = 3'h5,
    register_xor_op         = 3'h6,
    no_op                   = 3'h7
  } sswx_op_type;

  typedef struct packed {
    logic [7:0]  rsvd_hi;
    logic [7:0]  literal;
    logic [4:0]  rsvd_mid;
    logic [6:0]  findex;
    logic        dest;
    sswx_op_type op;
  } sswx_cmd_type;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } sswx_flags_type;

endpackage

/* core/sswx_core.sv */
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "sswx_defs.svh"

module sswx_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  port_one_direction,
  output logic      [7:0]  port_two_direction,
  output logic      [7:0]  port_three_direction
);

  logic [7:0]                file_q [0:`SSWX_FILE_LAST];
  logic [7:0]                acc_q;
  sswx_pkg::sswx_flags_type  flags_q;
  logic [7:0]                dir1_q;
  logic [7:0]                dir2_q;
  logic [7:0]                dir3_q;
  sswx_pkg::sswx_cmd_type    cmd_q;
  logic [31:0]               prdata_q;
  logic                      err_q;
  logic                      rdy_q;

  sswx_pkg::sswx_cmd_type    wcmd;
  logic                      in_win;
  logic [6:0]                win_idx;
  logic                      wr_en;
  logic                      exec;
  logic                      capture;
  logic [7:0]                fval;
  logic [9:0]                sub_r;
  logic [7:0]                res;
  sswx_pkg::sswx_flags_type  flags_d;
  logic                      to_acc;
  logic                      to_file;
  logic                      to_dir1;
  logic                      to_dir2;
  logic                      to_dir3;

  // two's complement a - b - !bin; returns {carry, nibble carry, result}
  function automatic logic [9:0] sub_fn(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       bin
  );
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'h0, a[`SSWX_NIB_LO]} + {1'h0, ~b[`SSWX_NIB_LO]} + {4'h0, bin};
    full = {1'h0, a} + {1'h0, ~b} + {8'h00, bin};
    sub_fn = {full[`SSWX_FULL_CY], lo[`SSWX_NIB_CY], full[`SSWX_BYTE]};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  function automatic logic is_dir_sel(input logic [6:0] f);
    is_dir_sel = (f == `SSWX_DIR_SEL1) || (f == `SSWX_DIR_SEL2) ||
                 (f == `SSWX_DIR_SEL3);
  endfunction

  // command accepted only for a legal operation and direction selector
  function automatic logic cmd_legal(input sswx_pkg::sswx_cmd_type c);
    logic ok;
    ok = 1'h1;
    if (c.op == sswx_pkg::no_op) begin
      ok = 1'h0;
    end
    if (c.op == sswx_pkg::direction_load_op && !is_dir_sel(c.findex)) begin
      ok = 1'h0;
    end
    cmd_legal = ok;
  endfunction

  // reserved command fields are stored as zero
  function automatic sswx_pkg::sswx_cmd_type cmd_clean(
    input sswx_pkg::sswx_cmd_type c
  );
    sswx_pkg::sswx_cmd_type r;
    r          = c;
    r.rsvd_hi  = 8'h00;
    r.rsvd_mid = 5'h00;
    cmd_clean  = r;
  endfunction

  assign wcmd    = sswx_pkg::sswx_cmd_type'(pwdata);
  assign in_win  = (paddr[`SSWX_WIN_SEL] == `SSWX_WIN_BASE);
  assign win_idx = paddr[`SSWX_WIN_IDX];
  assign fval    = file_q[wcmd.findex];

  // bus handshake: data captured in setup, answer in first access cycle
  assign pready  = psel & penable & rdy_q & ce;
  assign pslverr = err_q & pready;
  assign prdata  = prdata_q;
  assign wr_en   = pready & pwrite;
  assign exec    = wr_en & (paddr == `SSWX_OFS_CMD) & ~err_q;
  // setup cycle seen while idle: answer prepared for the access phase
  assign capture = ce & psel & ~rdy_q;

  assign port_one_direction   = dir1_q;
  assign port_two_direction   = dir2_q;
  assign port_three_direction = dir3_q;

  // operation datapath
  always_comb begin
    sub_r   = 10'h000;
    res     = 8'h00;
    flags_d = flags_q;
    to_acc  = 1'h0;
    to_file = 1'h0;
    to_dir1 = 1'h0;
    to_dir2 = 1'h0;
    to_dir3 = 1'h0;
    unique case (wcmd.op)
      sswx_pkg::literal_minus_acc_op: begin
        sub_r     = sub_fn(wcmd.literal, acc_q, 1'h1);
        res       = sub_r[`SSWX_BYTE];
        flags_d.c = sub_r[`SSWX_SUB_C];
        flags_d.dc = sub_r[`SSWX_SUB_DC];
        flags_d.z = is_zero(res);
        to_acc    = 1'h1;
      end
      sswx_pkg::register_minus_acc_op: begin
        sub_r     = sub_fn(fval, acc_q, 1'h1);
        res       = sub_r[`SSWX_BYTE];
        flags_d.c = sub_r[`SSWX_SUB_C];
        flags_d.dc = sub_r[`SSWX_SUB_DC];
        flags_d.z = is_zero(res);
        to_acc    = ~wcmd.dest;
        to_file   = wcmd.dest;
      end
      sswx_pkg::subtract_with_borrow_op: begin
        sub_r     = sub_fn(fval, acc_q, flags_q.c);
        res       = sub_r[`SSWX_BYTE];
        flags_d.c = sub_r[`SSWX_SUB_C];
        flags_d.dc = sub_r[`SSWX_SUB_DC];
        flags_d.z = is_zero(res);
        to_acc    = ~wcmd.dest;
        to_file   = wcmd.dest;
      end
      sswx_pkg::nibble_exchange_op: begin
        res     = {fval[`SSWX_NIB_LO], fval[`SSWX_NIB_HI]};
        to_acc  = ~wcmd.dest;
        to_file = wcmd.dest;
      end
      sswx_pkg::direction_load_op: begin
        res     = acc_q;
        to_dir1 = (wcmd.findex == `SSWX_DIR_SEL1);
        to_dir2 = (wcmd.findex == `SSWX_DIR_SEL2);
        to_dir3 = (wcmd.findex == `SSWX_DIR_SEL3);
      end
      sswx_pkg::literal_xor_op: begin
        res       = acc_q ^ wcmd.literal;
        flags_d.z = is_zero(res);
        to_acc    = 1'h1;
      end
      sswx_pkg::register_xor_op: begin
        res       = acc_q ^ fval;
        flags_d.z = is_zero(res);
        to_acc    = ~wcmd.dest;
        to_file   = wcmd.dest;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  // ready flag: set by a setup cycle, dropped when the access completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'h0;
    end else if (ce) begin
      if (pready) begin
        rdy_q <= 1'h0;
      end else if (capture) begin
        rdy_q <= 1'h1;
      end
    end
  end

  // bus setup capture: read data and error answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q    <= 1'h0;
      prdata_q <= 32'h0000_0000;
    end else if (capture) begin
      err_q    <= 1'h0;
      prdata_q <= 32'h0000_0000;
      if (in_win) begin
        prdata_q <= {24'h000000, file_q[win_idx]};
      end else begin
        unique case (paddr)
          `SSWX_OFS_CMD: begin
            prdata_q <= cmd_q;
            err_q    <= pwrite & ~cmd_legal(wcmd);
          end
          `SSWX_OFS_ACC: begin
            prdata_q <= {24'h000000, acc_q};
          end
          `SSWX_OFS_STAT: begin
            prdata_q <= {29'h0000000, flags_q};
          end
          `SSWX_OFS_DIR1: begin
            prdata_q <= {24'h000000, dir1_q};
          end
          `SSWX_OFS_DIR2: begin
            prdata_q <= {24'h000000, dir2_q};
          end
          `SSWX_OFS_DIR3: begin
            prdata_q <= {24'h000000, dir3_q};
          end
          default: begin
            err_q <= 1'h1;
          end
        endcase
      end
    end
  end

  // last accepted command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= sswx_pkg::sswx_cmd_type'(`SSWX_CMD_RST);
    end else if (ce && exec) begin
      cmd_q <= cmd_clean(wcmd);
    end
  end

  // accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= `SSWX_ACC_RST;
    end else if (ce) begin
      if (exec && to_acc) begin
        acc_q <= res;
      end else if (wr_en && paddr == `SSWX_OFS_ACC) begin
        acc_q <= pwdata[`SSWX_BYTE];
      end
    end
  end

  // status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= sswx_pkg::sswx_flags_type'(`SSWX_STAT_RST);
    end else if (ce) begin
      if (exec) begin
        flags_q <= flags_d;
      end else if (wr_en && paddr == `SSWX_OFS_STAT) begin
        flags_q <= sswx_pkg::sswx_flags_type'(pwdata[`SSWX_STAT_BITS]);
      end
    end
  end

  // port direction registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir1_q <= `SSWX_DIR_RST;
      dir2_q <= `SSWX_DIR_RST;
      dir3_q <= `SSWX_DIR_RST;
    end else if (ce && exec) begin
      if (to_dir1) begin
        dir1_q <= res;
      end
      if (to_dir2) begin
        dir2_q <= res;
      end
      if (to_dir3) begin
        dir3_q <= res;
      end
    end
  end

  // file registers, data only, not reset
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (exec && to_file) begin
        file_q[wcmd.findex] <= res;
      end else if (wr_en && in_win) begin
        file_q[win_idx] <= pwdata[`SSWX_BYTE];
      end
    end
  end

endmodule

/* bench/sswx_core_assertions.sv */
`timescale 1ns/10ps
module sswx_core_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_one_direction,
  input wire logic [7:0]  port_two_direction,
  input wire logic [7:0]  port_three_direction
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       cmd_wr;
  logic [2:0] op;
  logic [6:0] fi;
  assign cmd_wr = pready && pwrite && paddr == 12'h000;
  assign op = pwdata[2:0];
  assign fi = pwdata[10:4];
  a_ready_cause: assert property (pready |-> psel && penable && ce)
    else $error("pready outside an access");
  a_ready_first: assert property
    (psel && penable && ce && $past(psel && !penable && ce) |-> pready)
    else $error("pready late");
  a_dir_quiet: assert property (!(cmd_wr && op == 3'h4) |=>
    $stable({port_one_direction, port_two_direction, port_three_direction}))
    else $error("direction changed without load");
  a_dir_one_only: assert property
    (cmd_wr && op == 3'h4 && fi == 7'h05 && !pslverr |=>
     $stable({port_two_direction, port_three_direction}))
    else $error("wrong direction register loaded");
  a_bad_op_err: assert property (cmd_wr && op == 3'h7 |-> pslverr)
    else $error("illegal op accepted");
  a_bad_sel_err: assert property (cmd_wr && op == 3'h4 &&
    !(fi inside {7'h05, 7'h06, 7'h07}) |-> pslverr)
    else $error("bad selector accepted");
  a_good_cmd_ok: assert property (cmd_wr && op != 3'h7 && op != 3'h4 |->
    !pslverr) else $error("legal command refused");
  a_unmapped_err: assert property (pready && paddr == 12'h018 |-> pslverr)
    else $error("unmapped access accepted");
  a_err_gated: assert property (pslverr |-> pready)
    else $error("error without pready");
  c_borrow_sub: cover property (cmd_wr && op == 3'h2);
  c_dir_load: cover property (cmd_wr && op == 3'h4 && !pslverr);
  c_refused: cover property (pready && pslverr);
endmodule
bind sswx_core sswx_core_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_one_direction(port_one_direction),
  .port_two_direction(port_two_direction),
  .port_three_direction(port_three_direction));

/* bench/sswx_core_tb_top.sv */
`timescale 1ns/10ps
module sswx_core_tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, sv;
  logic [7:0]  d1, d2, d3;
  int          num_errors, n_checks;
  int          cyc = 0;
  sswx_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_one_direction(d1), .port_two_direction(d2),
    .port_three_direction(d3));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task stop_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; pready, read data and error taken at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task run(input logic [2:0] op, input logic dd, input logic [6:0] f,
           input logic [7:0] a, input logic [7:0] fv, input logic [7:0] k,
           input logic [2:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [2:0] ef;
    logic       t;
    apb(1, 12'h004, {24'h0, a});
    apb(1, 12'h008, {29'h0, fl});
    apb(1, {3'h1, f, 2'h0}, {24'h0, fv});
    apb(1, 12'h000, {8'h00, k, 5'h00, f, dd, op});
    chk({31'h0, er}, 0);
    ef = fl;
    r = a ^ fv;
    case (op)
      3'h0, 3'h1, 3'h2: begin
        s = {1'b0, op == 0 ? k : fv} + {1'b0, ~a} + (op == 2 ? fl[0] : 1'b1);
        h = {1'b0, op == 0 ? k[3:0] : fv[3:0]} + {1'b0, ~a[3:0]}
            + (op == 2 ? fl[0] : 1'b1);
        r = s[7:0];
        ef = {r == 0, h[4], s[8]};
      end
      3'h3: r = {fv[3:0], fv[7:4]};
      3'h5: r = a ^ k;
      default: r = a ^ fv;
    endcase
    if (op >= 3'h5) ef[2] = r == 0;
    t = dd && op != 0 && op != 5;
    rchk(12'h004, {24'h0, t ? a : r});
    rchk({3'h1, f, 2'h0}, {24'h0, t ? r : fv});
    rchk(12'h008, {29'h0, ef});
  endtask
  logic [7:0] av[3] = '{8'h35, 8'h36, 8'h0F};
  logic [7:0] fw[3] = '{8'h35, 8'h25, 8'hF0};
  logic [7:0] kv[3] = '{8'h35, 8'h25, 8'h10};
  logic [2:0] fg[3] = '{3'h0, 3'h7, 3'h1};
  logic [6:0] fx[3] = '{7'h00, 7'h40, 7'h7F};
  initial begin
    presetn = 0;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) rchk(12'h00C + 12'(4 * i), 32'hFF);
    rchk(12'h004, 0);
    rchk(12'h008, 0);
    rchk(12'h000, 32'h7);
    for (int o = 0; o < 7; o++) begin
      for (int d = 0; d < 2; d++) begin
        for (int i = 0; i < 3; i++) begin
          if (o != 4) run(3'(o), d[0], fx[i], av[i], fw[i], kv[i], fg[i]);
        end
      end
    end
    apb(0, 12'h008, 0);
    sv = rd;
    for (int i = 0; i < 3; i++) begin
      apb(1, 12'h004, 32'hA0 + i);
      apb(1, 12'h000, {8'hFF, 13'h0000, 7'(5 + i), 4'h4});
      chk({31'h0, er}, 0);
      rchk(12'h00C + 12'(4 * i), 32'hA0 + i);
    end
    chk({8'h0, d1, d2, d3}, 32'h00A0A1A2);
    rchk(12'h008, sv);
    apb(1, 12'h000, {21'h0, 7'h04, 4'h4});
    chk({31'h0, er}, 1);
    apb(1, 12'h000, 32'h7);
    chk({31'h0, er}, 1);
    apb(0, 12'h018, 0);
    chk({31'h0, er}, 1);
    chk(rd, 0);
    apb(1, 12'h00C, 32'h11);
    chk({31'h0, er}, 0);
    rchk(12'h00C, 32'hA0);
    rchk(12'h000, {21'h0, 7'h07, 4'h4});
    ce <= 1'h0;
    fork
      apb(1, 12'h004, 32'h5A);
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'h1;
      end
    join
    chk({31'h0, er}, 0);
    rchk(12'h004, 32'h5A);
    rchk(12'h00C, 32'hA0);
    stop_test;
  end
endmodule
